// [rtl/pdc_top.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Oscillator-stop opcode halts oscillator and CPU
// - Clock-gate opcode halts core, oscillator keeps running
// - Clock-gate exit resumes with no stabilisation wait
// - Float opcodes release port or all pins
// - Release opcode, interrupt low, reset low end floating
// - Any clock mode combines with any float
// - Step input pulls down while oscillator stopped
// - Decode 01H, 82H, A2H, C2H opcodes
// - Wake level held two strobes restarts CPU
// - External mode keeps bus, port-2 low nibble
module pdc_top #(
  parameter logic [7:0] FLOAT_REL_OPCODE = pdc_pkg::OPC_FLOAT_REL_DEF,
  parameter int         WAKE_STROBES     = pdc_pkg::WAKE_ALE_COUNT
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Instruction execute strobe from the core
  input  wire logic               instr_exec,
  input  wire logic [7:0]         instr_opcode,
  // Core status
  input  wire logic               ext_prog_mode,
  input  wire logic               int_enabled,
  input  wire logic               in_int_service,
  // Wake pins, address-latch strobe, supply-pin power-down
  input  wire logic               int_pin_n,
  input  wire logic               reset_pin_n,
  input  wire logic               ale_strobe,
  input  wire logic               supply_pd,
  // Clock control
  output logic                    osc_run,
  output logic                    core_clk_en,
  output logic                    cpu_hold,
  // Pin control
  output pdc_pkg::pdc_float_t     pin_float,
  output logic                    ss_pull_down,
  // Wake actions, one-cycle pulses
  output logic                    wake_take_int,
  output logic                    wake_resume,
  output logic                    wake_reset
);
  import pdc_pkg::*;

  initial begin
    if (WAKE_STROBES < 1 || WAKE_STROBES >= (1 << STROBE_CNT_W)) begin
      $error("pdc_top: WAKE_STROBES out of range");
    end
  end

  pdc_state_t      state_ff;
  pdc_state_t      nxt_state;
  pdc_state_t      sleep_mode_ff;
  pdc_state_t      nxt_sleep_mode;
  pdc_float_mode_t float_mode_ff;
  pdc_float_mode_t nxt_float_mode;
  pdc_float_t      nxt_pin_float;

  logic osc_run_ff;
  logic core_clk_en_ff;
  logic cpu_hold_ff;
  logic ss_pull_down_ff;
  logic wake_take_int_ff;
  logic wake_resume_ff;
  logic wake_reset_ff;

  // Opcode decode, only while the core is actually executing
  wire running      = (state_ff == PDC_RUN);
  wire exec_ok      = instr_exec && running;
  wire dec_gate     = exec_ok && (instr_opcode == OPC_CLOCK_GATE);
  wire dec_stop     = exec_ok && (instr_opcode == OPC_OSC_STOP);
  wire dec_pfloat   = exec_ok && (instr_opcode == OPC_PORT_FLOAT);
  wire dec_afloat   = exec_ok && (instr_opcode == OPC_ALL_FLOAT);
  wire dec_release  = exec_ok && (instr_opcode == FLOAT_REL_OPCODE);

  // Wake sources are level sensitive
  wire int_low      = !int_pin_n;
  wire rst_low      = !reset_pin_n;
  wire wake_low     = int_low || rst_low;
  wire asleep       = (state_ff == PDC_GATED) || (state_ff == PDC_OSC_STOP);
  wire waking       = (state_ff == PDC_WAKE);

  // Strobe count restarts whenever the level goes away
  wire strobes_done;
  wire cnt_clear    = !waking || !wake_low;

  pdc_strobe_cnt #(
    .W      (STROBE_CNT_W),
    .TARGET (WAKE_STROBES)
  ) u_wake_cnt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clear   (cnt_clear),
    .strobe  (ale_strobe),
    .reached (strobes_done)
  );

  wire wake_done    = waking && wake_low && strobes_done;
  wire wake_abort   = waking && !wake_low;

  // Clock mode sequencing
  always_comb begin
    nxt_state      = state_ff;
    nxt_sleep_mode = sleep_mode_ff;
    case (state_ff)
      PDC_RUN: begin
        if (dec_stop) begin
          nxt_state      = PDC_OSC_STOP;
          nxt_sleep_mode = PDC_OSC_STOP;
        end else if (dec_gate) begin
          nxt_state      = PDC_GATED;
          nxt_sleep_mode = PDC_GATED;
        end
      end
      PDC_GATED, PDC_OSC_STOP: begin
        if (wake_low) begin
          nxt_state = PDC_WAKE;
        end
      end
      PDC_WAKE: begin
        if (wake_done) begin
          // No stabilisation delay; the oscillator never stopped in gated
          // mode, and after a stop the step-pin capacitor holds the core
          nxt_state = PDC_RUN;
        end else if (wake_abort) begin
          // Level left too early: fall back into the mode we came from
          nxt_state = sleep_mode_ff;
        end
      end
      default: begin
        nxt_state = PDC_RUN;
      end
    endcase
  end

  // Float mode; any cancel source wins over a new float opcode
  wire float_cancel = dec_release || int_low || rst_low;
  assign nxt_float_mode = float_cancel ? PDC_FL_NONE :
                          dec_afloat   ? PDC_FL_ALL  :
                          dec_pfloat   ? PDC_FL_PORT :
                          float_mode_ff;

  // Pin groups per float mode and program mode
  wire any_float    = (nxt_float_mode != PDC_FL_NONE);
  wire all_float    = (nxt_float_mode == PDC_FL_ALL);
  wire int_prog     = !ext_prog_mode;

  always_comb begin
    nxt_pin_float          = FLOAT_NONE;
    nxt_pin_float.p1       = any_float ? P1_FLOAT_ALL : PORT_DRIVE_ALL;
    nxt_pin_float.p2       = !any_float    ? PORT_DRIVE_ALL :
                             ext_prog_mode ? P2_FLOAT_EXT :
                                             P2_FLOAT_ALL;
    nxt_pin_float.bus_port = any_float && int_prog;
    nxt_pin_float.ale      = all_float && int_prog;
    nxt_pin_float.psen     = all_float && int_prog;
    nxt_pin_float.prog     = all_float;
    nxt_pin_float.wr       = all_float;
    nxt_pin_float.pd       = all_float;
    nxt_pin_float.t0_out   = all_float;
  end

  // Clock and hold controls follow the next state so they line up with it
  wire nxt_osc_run  = (nxt_state != PDC_OSC_STOP);
  wire nxt_core_en  = (nxt_state == PDC_RUN) ||
                      (nxt_state == PDC_WAKE);
  wire nxt_hold     = (nxt_state != PDC_RUN);
  wire nxt_ss_pd    = (nxt_state == PDC_OSC_STOP) || supply_pd;

  // Wake action: reset pin outranks the interrupt pin
  wire act_reset    = wake_done && rst_low;
  wire act_int      = wake_done && !rst_low && int_enabled &&
                      !in_int_service;
  wire act_resume   = wake_done && !rst_low &&
                      !(int_enabled && !in_int_service);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= PDC_RUN;
      sleep_mode_ff <= PDC_GATED;
      float_mode_ff <= PDC_FL_NONE;
    end else begin
      state_ff      <= nxt_state;
      sleep_mode_ff <= nxt_sleep_mode;
      float_mode_ff <= nxt_float_mode;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_float       <= FLOAT_NONE;
      osc_run_ff      <= 1'b1;
      core_clk_en_ff  <= 1'b1;
      cpu_hold_ff     <= 1'b0;
      ss_pull_down_ff <= 1'b0;
    end else begin
      pin_float       <= nxt_pin_float;
      osc_run_ff      <= nxt_osc_run;
      core_clk_en_ff  <= nxt_core_en;
      cpu_hold_ff     <= nxt_hold;
      ss_pull_down_ff <= nxt_ss_pd;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_take_int_ff <= 1'b0;
      wake_resume_ff   <= 1'b0;
      wake_reset_ff    <= 1'b0;
    end else begin
      wake_take_int_ff <= act_int;
      wake_resume_ff   <= act_resume;
      wake_reset_ff    <= act_reset;
    end
  end

  assign osc_run       = osc_run_ff;
  assign core_clk_en   = core_clk_en_ff;
  assign cpu_hold      = cpu_hold_ff;
  assign ss_pull_down  = ss_pull_down_ff;
  assign wake_take_int = wake_take_int_ff;
  assign wake_resume   = wake_resume_ff;
  assign wake_reset    = wake_reset_ff;

endmodule : pdc_top
`default_nettype wire

// [rtl/pdc_pkg.sv]
`default_nettype none
package pdc_pkg;

  // Instruction codes decoded by the power-down block
  localparam logic [7:0] OPC_CLOCK_GATE      = 8'h01;
  localparam logic [7:0] OPC_OSC_STOP        = 8'h82;
  localparam logic [7:0] OPC_PORT_FLOAT      = 8'hA2;
  localparam logic [7:0] OPC_ALL_FLOAT       = 8'hC2;
  // Release code is not fixed by the pin-level behaviour; plain default
  localparam logic [7:0] OPC_FLOAT_REL_DEF   = 8'hE2;

  // Address-latch strobes a wake level must be held for
  localparam int         WAKE_ALE_COUNT      = 2;
  localparam int         STROBE_CNT_W        = 4;

  // Port 2 lanes that float in external-program mode; the low nibble keeps running
  localparam logic [7:0] P2_FLOAT_EXT        = 8'hF0;
  localparam logic [7:0] P2_FLOAT_ALL        = 8'hFF;
  localparam logic [7:0] P1_FLOAT_ALL        = 8'hFF;
  localparam logic [7:0] PORT_DRIVE_ALL      = 8'h00;

  typedef enum logic [3:0] {
    PDC_RUN      = 4'b0001,
    PDC_GATED    = 4'b0010,
    PDC_OSC_STOP = 4'b0100,
    PDC_WAKE     = 4'b1000
  } pdc_state_t;

  typedef enum logic [1:0] {
    PDC_FL_NONE = 2'h0,
    PDC_FL_PORT = 2'h1,
    PDC_FL_ALL  = 2'h2
  } pdc_float_mode_t;

  // One bit per pin group, one per pin on ports 1 and 2; high means the pin is released to Hi-Z
  typedef struct packed {
    logic       ale;
    logic       psen;
    logic       prog;
    logic       wr;
    logic       pd;
    logic       t0_out;
    logic [7:0] p1;
    logic [7:0] p2;
    logic       bus_port;
  } pdc_float_t;

  localparam pdc_float_t FLOAT_NONE = '0;

endpackage : pdc_pkg
`default_nettype wire

// [rtl/pdc_strobe_cnt.sv]
`timescale 1ns/10ps
`default_nettype none
module pdc_strobe_cnt #(
  parameter int W      = 4,
  parameter int TARGET = 2
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Control
  input  wire logic clear,
  input  wire logic strobe,
  // Status
  output logic      reached
);

  initial begin
    if (TARGET < 1 || TARGET >= (1 << W)) begin
      $error("pdc_strobe_cnt: TARGET does not fit counter width");
    end
  end

  localparam logic [W-1:0] TGT = W'(TARGET);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Saturates so a long-held wake level never wraps back below target
  assign nxt_cnt = clear                  ? '0 :
                   (strobe && cnt_ff != TGT) ? cnt_ff + W'(1) : cnt_ff;
  assign reached = (cnt_ff == TGT);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : pdc_strobe_cnt
`default_nettype wire

// [sim/pdc_chk_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module pdc_chk #(
  parameter logic [7:0] FLOAT_REL_OPCODE = pdc_pkg::OPC_FLOAT_REL_DEF
) (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rst_n,
  // Stimulus side
  input wire logic                instr_exec,
  input wire logic [7:0]          instr_opcode,
  input wire logic                ext_prog_mode,
  input wire logic                int_pin_n,
  input wire logic                reset_pin_n,
  input wire logic                supply_pd,
  // Design outputs
  input wire logic                osc_run,
  input wire logic                core_clk_en,
  input wire logic                cpu_hold,
  input wire pdc_pkg::pdc_float_t pin_float,
  input wire logic                ss_pull_down,
  input wire logic                wake_take_int,
  input wire logic                wake_resume,
  input wire logic                wake_reset
);
  import pdc_pkg::*;
  wire awake = int_pin_n && reset_pin_n;
  wire ok = instr_exec && !cpu_hold && awake;
  wire [2:0] wk = {wake_take_int, wake_resume, wake_reset};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_osc_stop: assert property (
    ok && instr_opcode == OPC_OSC_STOP |=> !osc_run && !core_clk_en && cpu_hold)
    else $error("osc stop not entered");
  a_clk_gate: assert property (
    ok && instr_opcode == OPC_CLOCK_GATE |=> osc_run && !core_clk_en && cpu_hold)
    else $error("clock gate not entered");
  a_port_float: assert property (
    ok && instr_opcode == OPC_PORT_FLOAT |=> pin_float.p1 == 8'hFF
    && pin_float.p2 == ($past(ext_prog_mode) ? 8'hF0 : 8'hFF)
    && pin_float.bus_port == !$past(ext_prog_mode))
    else $error("port float wrong");
  a_all_float: assert property (
    ok && instr_opcode == OPC_ALL_FLOAT |=> {pin_float.prog, pin_float.wr,
    pin_float.pd, pin_float.t0_out} == 4'hF && pin_float.ale ==
    !$past(ext_prog_mode) && pin_float.psen == !$past(ext_prog_mode))
    else $error("all float wrong");
  a_float_cancel: assert property (!awake |=> pin_float == FLOAT_NONE)
    else $error("float not cancelled by pin");
  a_float_rel: assert property (
    ok && instr_opcode == FLOAT_REL_OPCODE |=> pin_float == FLOAT_NONE)
    else $error("float not released");
  a_wake_clk: assert property (
    cpu_hold && !core_clk_en && !awake |=> osc_run && core_clk_en)
    else $error("clock not restarted");
  a_sleep_hold: assert property (
    cpu_hold && !core_clk_en && awake |=> cpu_hold && !core_clk_en
    && $stable(osc_run)) else $error("sleep state lost");
  a_pull_dir: assert property (
    ss_pull_down == (!osc_run || $past(supply_pd)))
    else $error("step pull wrong");
  a_wake_pulse: assert property (
    wk != 3'b000 |-> $onehot(wk) && $fell(cpu_hold))
    else $error("wake pulse wrong");
endmodule : pdc_chk
bind pdc_top pdc_chk #(.FLOAT_REL_OPCODE(FLOAT_REL_OPCODE)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .instr_exec(instr_exec),
  .instr_opcode(instr_opcode), .ext_prog_mode(ext_prog_mode),
  .int_pin_n(int_pin_n), .reset_pin_n(reset_pin_n), .supply_pd(supply_pd),
  .osc_run(osc_run), .core_clk_en(core_clk_en), .cpu_hold(cpu_hold),
  .pin_float(pin_float), .ss_pull_down(ss_pull_down),
  .wake_take_int(wake_take_int), .wake_resume(wake_resume),
  .wake_reset(wake_reset));
`default_nettype wire

// [sim/pdc_wake_src.sv]
`timescale 1ns/10ps
`default_nettype none
module pdc_wake_src (
  // Clock
  input  wire logic       clk_sys,
  // Request
  input  wire logic       start,
  input  wire logic       use_rst,
  input  wire logic [2:0] n_str,
  // Wake pins, pulled up when idle; address-latch strobe, low when idle
  output logic            int_pin_n   = 1'b1,
  output logic            reset_pin_n = 1'b1,
  output logic            ale_strobe  = 1'b0
);
  int cnt = 0;
  // Pin held low across n_str strobes plus margin
  always @(negedge clk_sys) begin
    if (start) begin
      cnt = 2 * n_str + 2;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
    end
    int_pin_n <= !(cnt > 0 && !use_rst);
    reset_pin_n <= !(cnt > 0 && use_rst);
    ale_strobe <= cnt > 2 && cnt[0];
  end
endmodule : pdc_wake_src
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pdc_pkg::*;
  logic clk_sys, rst_n, instr_exec, ext_prog_mode, int_enabled;
  logic in_int_service, supply_pd, start, use_rst;
  logic [7:0]  instr_opcode, fop, cop, op;
  logic [2:0]  n_str;
  logic [15:0] lfsr;
  int          n_mismatch, total_checks;
  wire         osc_run, core_clk_en, cpu_hold, ss_pull_down, ale_strobe;
  wire         wake_take_int, wake_resume, wake_reset, int_pin_n, reset_pin_n;
  pdc_float_t  pin_float;
  pdc_top i_pdc_top (.clk_sys(clk_sys), .rst_n(rst_n), .instr_exec(instr_exec),
    .instr_opcode(instr_opcode), .ext_prog_mode(ext_prog_mode),
    .int_enabled(int_enabled), .in_int_service(in_int_service),
    .int_pin_n(int_pin_n), .reset_pin_n(reset_pin_n), .ale_strobe(ale_strobe),
    .supply_pd(supply_pd), .osc_run(osc_run), .core_clk_en(core_clk_en),
    .cpu_hold(cpu_hold), .pin_float(pin_float), .ss_pull_down(ss_pull_down),
    .wake_take_int(wake_take_int), .wake_resume(wake_resume),
    .wake_reset(wake_reset));
  pdc_wake_src i_pdc_wake_src (.clk_sys(clk_sys), .start(start),
    .use_rst(use_rst), .n_str(n_str), .int_pin_n(int_pin_n),
    .reset_pin_n(reset_pin_n), .ale_strobe(ale_strobe));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt
  function automatic pdc_float_t exp_pins(input logic [7:0] o, input logic e);
    pdc_float_t f;
    f = FLOAT_NONE;
    f.p1 = 8'hFF;
    f.p2 = e ? 8'hF0 : 8'hFF;
    f.bus_port = !e;
    if (o == OPC_ALL_FLOAT) begin
      {f.prog, f.wr, f.pd, f.t0_out} = 4'hF;
      {f.ale, f.psen} = {2{!e}};
    end
    return f;
  endfunction : exp_pins
  function automatic logic [2:0] exp_wk(input logic r, input logic [2:0] n);
    if (n < WAKE_ALE_COUNT) return 3'h0;
    if (r) return 3'h1;
    return (int_enabled && !in_int_service) ? 3'h4 : 3'h2;
  endfunction : exp_wk
  // Wide enough for the pin group vector plus three status bits
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic exec(input logic [7:0] o);
    @(negedge clk_sys);
    instr_exec = 1'b1;
    instr_opcode = o;
    @(negedge clk_sys);
    instr_exec = 1'b0;
  endtask : exec
  task automatic wake(input logic r, input logic [2:0] n);
    logic [2:0] p;
    p = 3'h0;
    use_rst = r;
    n_str = n;
    // Non-blocking so the partner's falling-edge sampling sees no race
    start <= 1'b1;
    @(negedge clk_sys);
    start <= 1'b0;
    // Window covers the partner's whole low level
    repeat (20) begin
      @(negedge clk_sys);
      p = p | {wake_take_int, wake_resume, wake_reset};
    end
    chk(p, exp_wk(r, n));
  endtask : wake
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #40000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    {rst_n, instr_exec, ext_prog_mode, int_enabled} = 4'h0;
    {in_int_service, supply_pd, start, use_rst, n_str} = 7'h00;
    {instr_opcode, lfsr, n_mismatch, total_checks} = {8'h00, 16'h31FC, 64'h0};
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk({osc_run, core_clk_en, cpu_hold, ss_pull_down}, 4'hC);
    // Clock mode alone, no pin floating
    exec(OPC_OSC_STOP);
    chk({osc_run, core_clk_en, cpu_hold, pin_float}, {3'b001, FLOAT_NONE});
    wake(1'b0, 3'd3);
    chk({osc_run, core_clk_en, cpu_hold, ss_pull_down}, 4'hC);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      fop = i[0] ? OPC_ALL_FLOAT : OPC_PORT_FLOAT;
      cop = i[1] ? OPC_OSC_STOP : OPC_CLOCK_GATE;
      {in_int_service, int_enabled, ext_prog_mode} = lfsr[2:0];
      exec(fop);
      chk(pin_float, exp_pins(fop, ext_prog_mode));
      exec(cop);
      chk({osc_run, core_clk_en, cpu_hold, ss_pull_down},
          {!i[1], 2'b01, i[1]});
      chk(pin_float, exp_pins(fop, ext_prog_mode));
      if (i[2]) begin
        // Released after one strobe: back to the same sleep
        wake(lfsr[3], 3'd1);
        chk({osc_run, core_clk_en, cpu_hold}, {!i[1], 2'b01});
      end
      wake(lfsr[3], 3'd3);
      chk({osc_run, core_clk_en, cpu_hold, ss_pull_down}, 4'hC);
      chk(pin_float, FLOAT_NONE);
    end
    exec(OPC_PORT_FLOAT);
    exec(OPC_FLOAT_REL_DEF);
    chk(pin_float, FLOAT_NONE);
    repeat (6) begin
      lfsr = nxt(lfsr);
      op = lfsr[7:0];
      if (op inside {8'h01, 8'h82, 8'hA2, 8'hC2, 8'hE2}) op = 8'h00;
      exec(op);
      chk({cpu_hold, osc_run, pin_float}, {2'b01, FLOAT_NONE});
    end
    supply_pd = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(ss_pull_down, 1'b1);
    supply_pd = 1'b0;
    finish_test();
  end
endmodule : tb
`default_nettype wire
